// ---- src/decc_top.v ----
// Dual edge capture channel pair with capture test mode and DMA select
`include "decc_defines.vh"
module decc_top #(
    parameter [1:0] PAIR_INDEX = 2'd0 // Index of this channel pair
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        even_input,
    input  wire        odd_input,
    input  wire        dma_done_even,
    input  wire        dma_done_odd,
    output reg         irq_even,
    output reg         irq_odd,
    output reg         dma_req_even,
    output reg         dma_req_odd
);
    // Control and counter state
    reg        capture_test_enable;      // Test mode
    reg        pair_capture_mode_enable; // Pair mode
    reg        pair_capture_arm;         // Measurement armed
    reg        counter_run;              // Counter clock enable
    reg [`DECC_CW-1:0] counter_value_reg;
    reg [`DECC_CW-1:0] counter_start_value;
    reg [`DECC_CW-1:0] counter_wrap_limit;
    reg [`DECC_FW-1:0] filter_value;     // Even input filter length
    // Per channel status/control, index 0 even, 1 odd
    reg [1:0] channel_event_flag;
    reg [1:0] channel_irq_enable;
    reg [1:0] dma_select;
    reg [1:0] edge_select_high;
    reg [1:0] edge_select_low;
    reg       capture_repeat_select;     // Even channel bit only matters
    reg [1:0] flag_read_armed;           // Status read saw flag set
    // Captured values and coherency buffers
    reg [`DECC_CW-1:0] cap_even;
    reg [`DECC_CW-1:0] cap_odd;
    reg [`DECC_CW-1:0] buf_even;
    reg [`DECC_CW-1:0] buf_odd;
    reg                odd_pending;      // Odd buffer waits for even read
    reg                second_due;       // Second edge of pair awaited
    // Input synchroniser and filter
    reg       sync1;
    reg       sync2;
    reg       sync3;
    reg       in_state;                  // Filtered input level
    reg [`DECC_FW-1:0] filt_cnt;

    // Counter next value: wraps from limit to start
    function [`DECC_CW-1:0] decc_next;
        input [`DECC_CW-1:0] cur;
        input [`DECC_CW-1:0] lim;
        input [`DECC_CW-1:0] start;
        begin
            if (cur == lim)
                decc_next = start;
            else
                decc_next = cur + `DECC_ONE16;
        end
    endfunction

    // Edge match for a two-bit select code against an edge pair
    function decc_edge;
        input [1:0] code;
        input       rise;
        input       fall;
        begin
            decc_edge = ((code == `DECC_EDGE_RISE) && rise) ||
                        ((code == `DECC_EDGE_FALL) && fall);
        end
    endfunction

    // APB decode; zero wait states
    wire setup_wr = psel && !penable && pwrite;
    wire acc      = psel && penable;
    wire wr       = acc && pwrite;
    wire rd       = acc && !pwrite;
    wire mapped   = (paddr[1:0] == 2'b00) && (paddr <= `DECC_OFF_FILT);

    // Filter allowed only on pairs 0 and 2
    // filter gating by pair
    wire filt_ok  = (PAIR_INDEX == 2'd0) || (PAIR_INDEX == 2'd2);
    wire filt_on  = filt_ok && (filter_value != {`DECC_FW{1'b0}});

    // Three-stage synchroniser; a change counts when stages 2 and 3 agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= even_input;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Glitch filter: new level must hold filter_value cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_state <= 1'b0;
            filt_cnt <= {`DECC_FW{1'b0}};
        end else if (sync2 != sync3 || sync3 == in_state) begin
            // Unstable or unchanged: restart the count
            filt_cnt <= {`DECC_FW{1'b0}};
        end else if (!filt_on || filt_cnt == filter_value) begin
            in_state <= sync3;
            filt_cnt <= {`DECC_FW{1'b0}};
        end else begin
            filt_cnt <= filt_cnt + {{(`DECC_FW-1){1'b0}}, 1'b1};
        end
    end

    // Edge events on the even input; odd input is never looked at
    // even input only
    reg  in_prev;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            in_prev <= 1'b0;
        else
            in_prev <= in_state;
    end
    wire rise = in_state && !in_prev;
    wire fall = !in_state && in_prev;
    wire [1:0] code_e = {edge_select_high[0], edge_select_low[0]};
    wire [1:0] code_o = {edge_select_high[1], edge_select_low[1]};
    // Same codes give a period, different codes a pulse width
    // codes decide measurement
    wire hit_even = pair_capture_mode_enable && pair_capture_arm &&
                    decc_edge(code_e, rise, fall);
    wire hit_odd  = pair_capture_mode_enable && pair_capture_arm &&
                    channel_event_flag[0] && decc_edge(code_o, rise, fall);
    // In one-shot the even edge is taken once per arming
    // one pair per arm
    wire take_even = hit_even && !second_due &&
                     (capture_repeat_select || !channel_event_flag[0]);
    wire take_odd  = hit_odd && second_due;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            second_due <= 1'b0;
        else if (take_even || take_odd || !pair_capture_arm)
            second_due <= take_even;
    end

    wire test_wr = wr && (paddr == `DECC_OFF_CNT) && capture_test_enable;
    wire rd_sc0  = rd && (paddr == `DECC_OFF_SC0);
    wire rd_sc1  = rd && (paddr == `DECC_OFF_SC1);
    wire wr_sc0  = wr && (paddr == `DECC_OFF_SC0);
    wire wr_sc1  = wr && (paddr == `DECC_OFF_SC1);
    wire rd_cv0  = rd && (paddr == `DECC_OFF_CV0);

    // Counter and configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value_reg        <= `DECC_ZERO16;
            counter_start_value      <= `DECC_ZERO16;
            counter_wrap_limit       <= `DECC_MOD_RST;
            capture_test_enable      <= 1'b0;
            pair_capture_mode_enable <= 1'b0;
            counter_run              <= 1'b0;
            filter_value             <= {`DECC_FW{1'b0}};
        end else begin
            if (wr && paddr == `DECC_OFF_CTRL) begin
                capture_test_enable      <= pwdata[`DECC_CTRL_TEST];
                pair_capture_mode_enable <= pwdata[`DECC_CTRL_PAIREN];
                counter_run              <= pwdata[`DECC_CTRL_RUN];
            end
            if (wr && paddr == `DECC_OFF_COUNTER_START_VALUE)
                counter_start_value <= pwdata[`DECC_CW-1:0];
            if (wr && paddr == `DECC_OFF_MOD)
                counter_wrap_limit <= pwdata[`DECC_CW-1:0];
            if (wr && paddr == `DECC_OFF_FILT)
                filter_value <= pwdata[`DECC_FW-1:0];
            if (test_wr)
                counter_value_reg <= decc_next(pwdata[`DECC_CW-1:0],
                                               counter_wrap_limit,
                                               counter_start_value);
            else if (wr && paddr == `DECC_OFF_CNT)
                // Normal write reloads the start value
                counter_value_reg <= counter_start_value;
            else if (counter_run && !capture_test_enable)
                counter_value_reg <= decc_next(counter_value_reg,
                                               counter_wrap_limit,
                                               counter_start_value);
        end
    end

    // Arm bit: software sets, one-shot clears it on the second edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pair_capture_arm <= 1'b0;
        else if (take_odd && !capture_repeat_select)
            pair_capture_arm <= 1'b0;
        else if (wr && paddr == `DECC_OFF_CTRL)
            pair_capture_arm <= pwdata[`DECC_CTRL_ARM];
    end

    // Channel status/control fields
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_irq_enable    <= 2'b00;
            dma_select            <= 2'b00;
            edge_select_high      <= 2'b00;
            edge_select_low       <= 2'b00;
            capture_repeat_select <= 1'b0;
        end else begin
            if (wr_sc0) begin
                channel_irq_enable[0] <= pwdata[`DECC_SC_IRQEN];
                dma_select[0]         <= pwdata[`DECC_SC_DMA];
                edge_select_high[0]   <= pwdata[`DECC_SC_ELSH];
                edge_select_low[0]    <= pwdata[`DECC_SC_ELSL];
                capture_repeat_select <= pwdata[`DECC_SC_REPEAT];
            end
            if (wr_sc1) begin
                channel_irq_enable[1] <= pwdata[`DECC_SC_IRQEN];
                dma_select[1]         <= pwdata[`DECC_SC_DMA];
                edge_select_high[1]   <= pwdata[`DECC_SC_ELSH];
                edge_select_low[1]    <= pwdata[`DECC_SC_ELSL];
            end
        end
    end

    // Event flags: hardware set wins over every clear
    reg [1:0] set_f;
    reg [1:0] clr_f;
    reg [1:0] sw_clr;
    integer i;
    always @* begin
        set_f  = {take_odd, take_even};
        sw_clr = {wr_sc1 && !pwdata[`DECC_SC_FLAG] && flag_read_armed[1],
                  wr_sc0 && !pwdata[`DECC_SC_FLAG] && flag_read_armed[0]};
        if (test_wr)
            set_f = 2'b11;
        for (i = 0; i < 2; i = i + 1) begin
            if (dma_select[i] && channel_irq_enable[i])
                clr_f[i] = (i == 0) ? dma_done_even : dma_done_odd;
            else
                // DMA done or read then write zero
                clr_f[i] = (dma_select[i] &&
                            ((i == 0) ? dma_done_even : dma_done_odd)) ||
                           sw_clr[i];
        end
        if (pair_capture_mode_enable && capture_repeat_select &&
            pair_capture_arm)
            clr_f[0] = 1'b0;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_event_flag <= 2'b00;
            flag_read_armed    <= 2'b00;
        end else begin
            channel_event_flag <= set_f | (channel_event_flag & ~clr_f);
            // Remember a status read that saw the flag set
            if (rd_sc0 && channel_event_flag[0])
                flag_read_armed[0] <= 1'b1;
            else if (wr_sc0)
                flag_read_armed[0] <= 1'b0;
            if (rd_sc1 && channel_event_flag[1])
                flag_read_armed[1] <= 1'b1;
            else if (wr_sc1)
                flag_read_armed[1] <= 1'b0;
        end
    end

    // Captures; pair mode goes through buffers for read coherency
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_even    <= `DECC_ZERO16;
            cap_odd     <= `DECC_ZERO16;
            buf_even    <= `DECC_ZERO16;
            buf_odd     <= `DECC_ZERO16;
            odd_pending <= 1'b0;
        end else if (test_wr) begin
            cap_even    <= pwdata[`DECC_CW-1:0];
            cap_odd     <= pwdata[`DECC_CW-1:0];
            odd_pending <= 1'b0;
        end else begin
            if (take_even)
                buf_even <= counter_value_reg;
            if (take_odd) begin
                cap_even    <= buf_even;
                buf_odd     <= counter_value_reg;
                odd_pending <= 1'b1;
            end else if (rd_cv0 && odd_pending) begin
                // Odd value moves only once the even one is read
                // even read releases odd
                cap_odd     <= buf_odd;
                odd_pending <= 1'b0;
            end
        end
    end

    // Read mux
    reg [31:0] next_prdata;
    always @* begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            `DECC_OFF_CTRL:  next_prdata = {28'h0, counter_run,
                                 pair_capture_arm, pair_capture_mode_enable,
                                 capture_test_enable};
            `DECC_OFF_CNT:   next_prdata = {16'h0, counter_value_reg};
            `DECC_OFF_COUNTER_START_VALUE: next_prdata = {16'h0, counter_start_value};
            `DECC_OFF_MOD:   next_prdata = {16'h0, counter_wrap_limit};
            `DECC_OFF_SC0:   next_prdata = {24'h0, channel_event_flag[0],
                                 channel_irq_enable[0], 1'b0,
                                 capture_repeat_select, edge_select_high[0],
                                 edge_select_low[0], 1'b0, dma_select[0]};
            `DECC_OFF_SC1:   next_prdata = {24'h0, channel_event_flag[1],
                                 channel_irq_enable[1], 2'b00,
                                 edge_select_high[1], edge_select_low[1],
                                 1'b0, dma_select[1]};
            `DECC_OFF_CV0:   next_prdata = {16'h0, cap_even};
            `DECC_OFF_CV1:   next_prdata = {16'h0, cap_odd};
            `DECC_OFF_FILT:  next_prdata = {28'h0, filter_value};
            default:         next_prdata = 32'h0000_0000;
        endcase
    end

    // APB outputs: data registered in setup, pready in access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !setup_wr)
                prdata <= next_prdata;
        end
    end

    // Request outputs
    // DMA select steers request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_even     <= 1'b0;
            irq_odd      <= 1'b0;
            dma_req_even <= 1'b0;
            dma_req_odd  <= 1'b0;
        end else begin
            irq_even     <= channel_event_flag[0] &&
                            channel_irq_enable[0] && !dma_select[0];
            irq_odd      <= channel_event_flag[1] &&
                            channel_irq_enable[1] && !dma_select[1];
            dma_req_even <= channel_event_flag[0] &&
                            channel_irq_enable[0] && dma_select[0];
            dma_req_odd  <= channel_event_flag[1] &&
                            channel_irq_enable[1] && dma_select[1];
        end
    end
endmodule

// ---- pkg/decc_defines.vh ----
// Register offsets, field positions and constants for the capture pair
`ifndef DECC_DEFINES_VH
`define DECC_DEFINES_VH
// Byte offsets of the APB registers
`define DECC_OFF_CTRL     12'h000
`define DECC_OFF_CNT      12'h004
`define DECC_OFF_COUNTER_START_VALUE    12'h008
`define DECC_OFF_MOD      12'h00c
`define DECC_OFF_SC0      12'h010
`define DECC_OFF_SC1      12'h014
`define DECC_OFF_CV0      12'h018
`define DECC_OFF_CV1      12'h01c
`define DECC_OFF_FILT     12'h020
// Control register fields
`define DECC_CTRL_TEST    0
`define DECC_CTRL_PAIREN  1
`define DECC_CTRL_ARM     2
`define DECC_CTRL_RUN     3
// Channel status/control fields
`define DECC_SC_FLAG      7
`define DECC_SC_IRQEN     6
`define DECC_SC_REPEAT    4
`define DECC_SC_ELSH      3
`define DECC_SC_ELSL      2
`define DECC_SC_DMA       0
// Edge select codes
`define DECC_EDGE_RISE    2'b01
`define DECC_EDGE_FALL    2'b10
// Widths and reset values
`define DECC_CW           16
`define DECC_FW           4
`define DECC_PAIR_BASE    2'd0
`define DECC_ZERO16       16'h0000
`define DECC_MOD_RST      16'hffff
`define DECC_ONE16        16'h0001
`endif

// ---- tb/decc_props.sv ----
// Concurrent checks on the capture pair's bus and request ports
module decc_props (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        even_input,
    input wire        odd_input,
    input wire        dma_done_even,
    input wire        dma_done_odd,
    input wire        irq_even,
    input wire        irq_odd,
    input wire        dma_req_even,
    input wire        dma_req_odd
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Word aligned offsets inside the map answer cleanly
    wire mapped = (paddr <= 12'h020) && (paddr[1:0] == 2'b00);
    // Setup cycle of a bus transfer
    wire setup  = psel && !penable;
    ready_after_setup_a: assert property (setup |=> pready && penable)
        else $error("ready missing in access cycle");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held past access cycle");
    ready_idle_a: assert property (!psel |=> !pready)
        else $error("ready without selection");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag outside access cycle");
    unmapped_refused_a: assert property (setup && !mapped && !pwrite
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    mapped_ok_a: assert property (setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    irq_dma_even_a: assert property (!(irq_even && dma_req_even))
        else $error("even irq and request together");
    irq_dma_odd_a: assert property (!(irq_odd && dma_req_odd))
        else $error("odd irq and request together");
    dma_done_clear_a: assert property (dma_done_even && dma_req_even
        |-> ##[1:3] !dma_req_even)
        else $error("transfer done left request standing");
endmodule

bind decc_top decc_props decc_props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .even_input(even_input),
    .odd_input(odd_input), .dma_done_even(dma_done_even),
    .dma_done_odd(dma_done_odd), .irq_even(irq_even), .irq_odd(irq_odd),
    .dma_req_even(dma_req_even), .dma_req_odd(dma_req_odd)
);

// ---- tb/decc_far_side_model.sv ----
// Far side of the pair: measured signal source and DMA engine
module decc_far_side_model (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        pulse_go,
    input  wire        pulse_pol,
    input  wire [7:0]  pulse_len,
    input  wire        period_run,
    input  wire [3:0]  dma_lag,
    input  wire        dma_req_even,
    input  wire        dma_req_odd,
    output logic       even_input,
    output logic       odd_input,
    output wire        dma_done_even,
    output wire        dma_done_odd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left;          // Cycles left at the current level
    logic [4:0] wt [2];        // Service delay per channel
    logic [1:0] hold;          // Waits for the request to drop
    logic [1:0] done;          // One-cycle completion pulses
    wire  [1:0] req = {dma_req_odd, dma_req_even};
    assign dma_done_even = done[0];
    assign dma_done_odd  = done[1];
    // Signal source; odd line toggles as noise the pair must ignore
    // idle and pulse levels
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            even_input <= 1'b0;
            odd_input  <= 1'b0;
            left       <= 8'h00;
        end else begin
            odd_input <= ~odd_input;
            if (pulse_go) begin
                even_input <= pulse_pol;
                left       <= pulse_len;
            end else if (left > 8'h01) begin
                left <= left - 8'h01;
            end else if (left == 8'h01 && period_run) begin
                even_input <= ~even_input;
                left       <= pulse_len;
            end else begin
                even_input <= ~pulse_pol;
                left       <= 8'h00;
            end
        end
    end
    // DMA engine; hold stops a second completion while request lags
    // completion pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done  <= 2'b00;
            hold  <= 2'b00;
            wt[0] <= 5'h00;
            wt[1] <= 5'h00;
        end else begin
            for (int k = 0; k < 2; k++) begin
                done[k] <= 1'b0;
                if (!req[k])
                    hold[k] <= 1'b0;
                if (req[k] && !hold[k] && wt[k] == 5'h00) begin
                    wt[k] <= {1'b0, dma_lag} + 5'h01;
                end else if (wt[k] == 5'h01) begin
                    done[k] <= 1'b1;
                    hold[k] <= 1'b1;
                    wt[k]   <= 5'h00;
                end else if (wt[k] != 5'h00) begin
                    wt[k] <= wt[k] - 5'h01;
                end
            end
        end
    end
endmodule

// ---- tb/decc_top_tb.sv ----
// Self-checking bench for the dual edge capture pair
`include "decc_defines.vh"
module decc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic dma; logic ie; logic [15:0] val; logic [3:0] lag;
        logic irq; logic req; logic flag;
    } decc_row_t;
    // Test writes: selection, enable, value, lag, then expected outputs
    decc_row_t rows [5] = '{'{1'b0, 1'b0, 16'h0000, 4'h4, 1'b0, 1'b0, 1'b1},
        '{1'b0, 1'b1, 16'h1234, 4'h4, 1'b1, 1'b0, 1'b1},
        '{1'b1, 1'b0, 16'hffff, 4'h4, 1'b0, 1'b0, 1'b1},
        '{1'b1, 1'b1, 16'h8001, 4'h4, 1'b0, 1'b1, 1'b0},
        '{1'b1, 1'b1, 16'h7ffe, 4'h9, 1'b0, 1'b1, 1'b0}};
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, er, pulse_go = 1'b0;
    logic        pulse_pol = 1'b1, period_run = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, v0, v1, sc;
    logic [7:0]  pulse_len = 8'h05;
    logic [3:0]  dma_lag = 4'h4;
    logic [15:0] nxt;
    decc_row_t   r;
    wire  [31:0] prdata;
    wire         pready, pslverr, even_input, odd_input, dma_done_even;
    wire         dma_done_odd, irq_even, irq_odd, dma_req_even, dma_req_odd;
    int          fails = 0, samples_checked = 0, n;
    decc_top decc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .even_input(even_input), .odd_input(odd_input),
        .dma_done_even(dma_done_even), .dma_done_odd(dma_done_odd),
        .irq_even(irq_even), .irq_odd(irq_odd),
        .dma_req_even(dma_req_even), .dma_req_odd(dma_req_odd));
    decc_far_side_model decc_far_side_model_i (.pclk(pclk),
        .presetn(presetn), .pulse_go(pulse_go), .pulse_pol(pulse_pol),
        .pulse_len(pulse_len), .period_run(period_run), .dma_lag(dma_lag),
        .dma_req_even(dma_req_even), .dma_req_odd(dma_req_odd),
        .even_input(even_input), .odd_input(odd_input),
        .dma_done_even(dma_done_even), .dma_done_odd(dma_done_odd));
    // Clock at 250 MHz
    always #2 pclk = ~pclk;
    task chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus transfer; holds the request until ready is sampled high
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        fails += (n >= 64);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task final_report;
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Read a flag, then write config back with flag zero
    task clr(input logic [11:0] a, input logic [31:0] cfg);
        bus(1'b0, a, 32'h0);
        bus(1'b1, a, cfg);
    endtask
    task pulse(input logic [7:0] wait_n);
        pulse_go <= 1'b1;
        @(posedge pclk);
        pulse_go <= 1'b0;
        repeat (wait_n) @(posedge pclk);
    endtask
    // one-shot run on a single pulse of given polarity
    task one_shot(input logic pol, input logic [7:0] len, input logic [1:0] e0,
                  input logic [1:0] e1);
        pulse_pol <= pol;
        pulse_len <= len;
        clr(`DECC_OFF_SC0, {26'h0, e0, 2'b00});
        clr(`DECC_OFF_SC1, {26'h0, e1, 2'b00});
        bus(1'b1, `DECC_OFF_CTRL, 32'he);
        pulse(8'd40);
        bus(1'b0, `DECC_OFF_CTRL, 32'h0);
        chk("arm bit", rd[2], 1'b0);
        bus(1'b0, `DECC_OFF_SC1, 32'h0);
        chk("odd flag", rd[7], 1'b1);
        bus(1'b0, `DECC_OFF_CV0, 32'h0);
        v0 = rd;
        bus(1'b0, `DECC_OFF_CV1, 32'h0);
        v1 = rd;
        chk("pulse width", v1[15:0] - v0[15:0], {8'h00, len});
        pulse(8'd40);
        bus(1'b0, `DECC_OFF_CV0, 32'h0);
        chk("even kept", rd, v0);
        bus(1'b0, `DECC_OFF_CV1, 32'h0);
        chk("odd kept", rd, v1);
    endtask
    task wait_odd_irq;
        n = 0;
        while (irq_odd !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        fails += (n >= 300);
    endtask
    // Watchdog well past the expected run
    initial begin
        #80000;
        fails++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // test writes across every selection and enable row
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            sc = {25'h0, r.ie, 4'h1, 1'b0, r.dma};
            dma_lag <= r.lag;
            bus(1'b1, `DECC_OFF_SC0, sc);
            bus(1'b1, `DECC_OFF_SC1, sc);
            bus(1'b1, `DECC_OFF_CTRL, 32'h9);
            bus(1'b1, `DECC_OFF_CNT, {16'h0, r.val});
            repeat (3) @(posedge pclk);
            chk("irq even", irq_even, r.irq);
            chk("irq odd", irq_odd, r.irq);
            chk("req even", dma_req_even, r.req);
            chk("req odd", dma_req_odd, r.req);
            repeat (16) @(posedge pclk);
            nxt = (r.val == 16'hffff) ? 16'h0000 : r.val + 16'h0001;
            bus(1'b0, `DECC_OFF_CNT, 32'h0);
            chk("counter", rd, {16'h0, nxt});
            bus(1'b0, `DECC_OFF_CV0, 32'h0);
            chk("capture even", rd, {16'h0, r.val});
            bus(1'b0, `DECC_OFF_CV1, 32'h0);
            chk("capture odd", rd, {16'h0, r.val});
            bus(1'b0, `DECC_OFF_SC0, 32'h0);
            chk("flag even", rd[7], r.flag);
            bus(1'b1, `DECC_OFF_SC0, sc);
            clr(`DECC_OFF_SC1, sc);
            bus(1'b0, `DECC_OFF_SC0, 32'h0);
            chk("flag cleared", rd[7], 1'b0);
            chk("irq low", irq_even, 1'b0);
        end
        // Second reset in mid-run restores the reset values
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("irq in reset", {irq_even, irq_odd, dma_req_even}, 32'h0);
        presetn <= 1'b1;
        bus(1'b0, `DECC_OFF_MOD, 32'h0);
        chk("wrap limit", rd, 32'h0000_ffff);
        bus(1'b0, `DECC_OFF_CTRL, 32'h0);
        chk("control", rd, 32'h0);
        bus(1'b0, 12'h024, 32'h0);
        chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
        bus(1'b1, 12'h006, 32'h5);
        chk("unaligned", er, 1'b1);
        one_shot(1'b1, 8'd7, `DECC_EDGE_RISE, `DECC_EDGE_FALL);
        one_shot(1'b0, 8'd5, `DECC_EDGE_FALL, `DECC_EDGE_RISE);
        // continuous period run, odd irq marks each new pair
        pulse_pol <= 1'b1;
        pulse_len <= 8'h20;
        clr(`DECC_OFF_SC0, 32'h14);
        clr(`DECC_OFF_SC1, 32'h44);
        bus(1'b1, `DECC_OFF_CTRL, 32'he);
        period_run <= 1'b1;
        pulse(8'd150);
        wait_odd_irq();
        clr(`DECC_OFF_SC1, 32'h44);
        bus(1'b0, `DECC_OFF_SC1, 32'h0);
        chk("odd cleared", rd[7], 1'b0);
        wait_odd_irq();
        chk("odd set again", irq_odd, 1'b1);
        bus(1'b0, `DECC_OFF_CV0, 32'h0);
        v0 = rd;
        bus(1'b0, `DECC_OFF_CV1, 32'h0);
        chk("period", rd[15:0] - v0[15:0], 32'h40);
        bus(1'b1, `DECC_OFF_CTRL, 32'ha);
        period_run <= 1'b0;
        repeat (150) @(posedge pclk);
        bus(1'b0, `DECC_OFF_CV0, 32'h0);
        v0 = rd;
        bus(1'b0, `DECC_OFF_CV1, 32'h0);
        chk("period kept", rd[15:0] - v0[15:0], 32'h40);
        final_report();
    end
endmodule
